// ==== core/tofs_sequencer.v ====
// Function
// - Long-range: start fraction first, stop n next
// - No stop overflows; no start waits forever
// - Count to last stop, store each stop
// - One to five stops per measurement
// - Averaging runs alone, interrupts after series
// - Averaging count one to one hundred twenty-eight
// - After calibration, retrigger or raise interrupt
// - Start bit raises the trigger output
// - Then wait for start; start drops trigger
// - Counter starts next reference edge; mask sets window
// - Stops accepted only after mask count reached
// - Last stop: interrupt, pins off, or retrigger
// - Restart by setting start bit only
// - Enable low resets all registers to defaults
// - Write command plus byte; read 8/24 clocks
// - Command: auto-increment, direction, six-bit address
// - Device only answers host serial transactions
// - Any overflow ends the measurement at once
// - Sample on rising clock, MSB first, excess ignored
// - Chip select high aborts; low readies interface
`timescale 1ns/1ps
`include "tofs_consts.vh"

module tofs_sequencer (
    clk_sys,
    rst_n,
    sclk,
    chip_select_n,
    din,
    dout,
    dout_oe_n,
    start_in,
    stop_in,
    trigger_out,
    interrupt_out_n
);
    input wire clk_sys;
    input wire rst_n;
    input wire sclk;
    input wire chip_select_n;
    input wire din;
    output reg dout;
    output reg dout_oe_n;
    input wire start_in;
    input wire stop_in;
    output reg trigger_out;
    output reg interrupt_out_n;

    localparam [3:0] ST_IDLE = 4'h1;
    localparam [3:0] ST_ARMED = 4'h2;
    localparam [3:0] ST_RUN = 4'h4;
    localparam [3:0] ST_CAL = 4'h8;

    integer i;
    wire [4:0] pins_s;
    reg sclk_prev_ff;
    reg start_prev_ff;
    reg stop_prev_ff;
    reg [7:0] first_setup_reg_ff;
    reg [7:0] second_setup_reg_ff;
    reg [7:0] status_ff;
    reg [7:0] mask_ff;
    reg [7:0] coarse_ovf_high_ff;
    reg [7:0] coarse_ovf_low_ff;
    reg [7:0] clock_ovf_high_ff;
    reg [7:0] clock_ovf_low_ff;
    reg [7:0] stop_window_high_ff;
    reg [7:0] stop_window_low_ff;
    reg [23:0] fine_time_result_ff [0:5];
    reg [23:0] clock_cycle_result_ff [0:4];
    reg [23:0] cal_single_period_result_ff;
    reg [23:0] cal_multi_period_result_ff;
    reg [3:0] state_ff;
    reg [23:0] cnt_ff;
    reg [23:0] cal_cnt_ff;
    reg [2:0] stop_idx_ff;
    reg [7:0] avg_cnt_ff;
    reg sp_cmd_ff;
    reg sp_done_ff;
    reg sp_ai_ff;
    reg sp_wr_ff;
    reg [5:0] sp_addr_ff;
    reg [4:0] sp_bit_ff;
    reg [7:0] sp_shin_ff;
    reg [23:0] sp_shout_ff;
    reg wr_stb_ff;
    reg [5:0] wr_addr_ff;
    reg [7:0] wr_data_ff;

    // Pins from the host and the front end cross into the reference clock domain.
    tofs_sync2 #(
        .WIDTH(5)
    ) u_sync (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .d({stop_in, start_in, din, chip_select_n, sclk}),
        .q(pins_s)
    );

    wire sclk_s = pins_s[0];
    wire cs_n_s = pins_s[1];
    wire din_s = pins_s[2];
    wire start_s = pins_s[3];
    wire stop_s = pins_s[4];
    wire sclk_rise = sclk_s & ~sclk_prev_ff;
    wire sclk_fall = ~sclk_s & sclk_prev_ff;

    // Edge polarity per pin; a set bit selects the falling edge.
    wire start_hit = first_setup_reg_ff[`TOFS_S1_START_EDGE] ? (~start_s & start_prev_ff)
        : (start_s & ~start_prev_ff);
    wire stop_hit = first_setup_reg_ff[`TOFS_S1_STOP_EDGE] ? (~stop_s & stop_prev_ff)
        : (stop_s & ~stop_prev_ff);

    wire long_mode = first_setup_reg_ff[`TOFS_S1_MODE];
    wire [2:0] nstop_sel = second_setup_reg_ff[`TOFS_S2_NSTOP_HI:`TOFS_S2_NSTOP_LO];
    wire [2:0] last_stop = (nstop_sel > `TOFS_LAST_STOP) ? `TOFS_LAST_STOP : nstop_sel;
    wire [2:0] avg_sel = second_setup_reg_ff[`TOFS_S2_AVG_HI:`TOFS_S2_AVG_LO];
    wire [7:0] avg_target = (8'h01 << avg_sel) - 8'h01;
    wire avg_last = (avg_cnt_ff == avg_target);
    wire [1:0] cal_sel = second_setup_reg_ff[`TOFS_S2_CAL_HI:`TOFS_S2_CAL_LO];
    wire [23:0] cal_len = (cal_sel == 2'h0) ? `TOFS_CAL_P0 : (cal_sel == 2'h1) ? `TOFS_CAL_P1
        : (cal_sel == 2'h2) ? `TOFS_CAL_P2 : `TOFS_CAL_P3;
    wire [23:0] stop_window = {8'h00, stop_window_high_ff, stop_window_low_ff};
    wire [23:0] clock_ovf = {8'h00, clock_ovf_high_ff, clock_ovf_low_ff};
    wire [23:0] coarse_ovf = {8'h00, coarse_ovf_high_ff, coarse_ovf_low_ff};
    wire stop_open = (cnt_ff >= stop_window);
    wire kov_hit = long_mode && (cnt_ff > clock_ovf);
    wire cov_hit = !long_mode && (cnt_ff >= coarse_ovf);
    wire [7:0] cmd_byte = {sp_shin_ff[6:0], din_s};

    // Read value for an address, left aligned so the MSB always leaves first.
    function [23:0] rd_word;
        input [5:0] a;
        begin
            rd_word = `TOFS_RST_RES;
            if (a == `TOFS_ADDR_SETUP1)
                rd_word = {first_setup_reg_ff, 16'h0000};
            else if (a == `TOFS_ADDR_SETUP2)
                rd_word = {second_setup_reg_ff, 16'h0000};
            else if (a == `TOFS_ADDR_STATUS)
                rd_word = {status_ff, 16'h0000};
            else if (a == `TOFS_ADDR_MASK)
                rd_word = {mask_ff, 16'h0000};
            else if (a == `TOFS_ADDR_COV_H)
                rd_word = {coarse_ovf_high_ff, 16'h0000};
            else if (a == `TOFS_ADDR_COV_L)
                rd_word = {coarse_ovf_low_ff, 16'h0000};
            else if (a == `TOFS_ADDR_KOV_H)
                rd_word = {clock_ovf_high_ff, 16'h0000};
            else if (a == `TOFS_ADDR_KOV_L)
                rd_word = {clock_ovf_low_ff, 16'h0000};
            else if (a == `TOFS_ADDR_SWIN_H)
                rd_word = {stop_window_high_ff, 16'h0000};
            else if (a == `TOFS_ADDR_SWIN_L)
                rd_word = {stop_window_low_ff, 16'h0000};
            else if (a >= `TOFS_ADDR_RES_FIRST && a <= `TOFS_ADDR_RES_LAST)
                rd_word = a[0] ? clock_cycle_result_ff[a[3:1]] : fine_time_result_ff[a[3:1]];
            else if (a == `TOFS_ADDR_CAL1)
                rd_word = cal_single_period_result_ff;
            else if (a == `TOFS_ADDR_CAL2)
                rd_word = cal_multi_period_result_ff;
        end
    endfunction

    wire sp_short = (sp_addr_ff < `TOFS_ADDR_RES_FIRST);
    wire [4:0] sp_end = sp_short ? `TOFS_BYTE_END : `TOFS_WORD_END;

    // Serial slave: sample on rising serial clock, shift out on falling.
    // Chip select high clears the command flag, done flag and bit count, so a half frame never reaches a register.
    always @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            sclk_prev_ff <= 1'b0;
            sp_cmd_ff <= 1'b0;
            sp_done_ff <= 1'b0;
            sp_ai_ff <= 1'b0;
            sp_wr_ff <= 1'b0;
            sp_addr_ff <= 6'h00;
            sp_bit_ff <= 5'h00;
            sp_shin_ff <= 8'h00;
            sp_shout_ff <= `TOFS_RST_RES;
            wr_stb_ff <= 1'b0;
            wr_addr_ff <= 6'h00;
            wr_data_ff <= 8'h00;
            dout <= 1'b0;
            dout_oe_n <= 1'b1;
        end
        else
        begin
            sclk_prev_ff <= sclk_s;
            wr_stb_ff <= 1'b0;
            dout_oe_n <= ~(sp_cmd_ff & ~sp_wr_ff & ~cs_n_s);
            if (cs_n_s)
            begin
                sp_cmd_ff <= 1'b0;
                sp_done_ff <= 1'b0;
                sp_bit_ff <= 5'h00;
            end
            else if (sclk_rise && !sp_done_ff)
            begin
                sp_shin_ff <= cmd_byte;
                sp_bit_ff <= sp_bit_ff + 5'h01;
                if (!sp_cmd_ff && sp_bit_ff == `TOFS_BYTE_END)
                begin
                    sp_cmd_ff <= 1'b1;
                    sp_ai_ff <= cmd_byte[`TOFS_CMD_AI];
                    sp_wr_ff <= cmd_byte[`TOFS_CMD_WR];
                    sp_addr_ff <= cmd_byte[`TOFS_CMD_ADDR_HI:0];
                    sp_shout_ff <= rd_word(cmd_byte[`TOFS_CMD_ADDR_HI:0]);
                    sp_bit_ff <= 5'h00;
                end
                else if (sp_cmd_ff && sp_wr_ff && sp_bit_ff == `TOFS_BYTE_END)
                begin
                    wr_stb_ff <= 1'b1;
                    wr_addr_ff <= sp_addr_ff;
                    wr_data_ff <= cmd_byte;
                    sp_bit_ff <= 5'h00;
                    sp_addr_ff <= sp_addr_ff + 6'h01;
                    sp_done_ff <= ~sp_ai_ff;
                end
                else if (sp_cmd_ff && !sp_wr_ff && sp_bit_ff == sp_end)
                begin
                    sp_bit_ff <= 5'h00;
                    sp_addr_ff <= sp_addr_ff + 6'h01;
                    sp_shout_ff <= rd_word(sp_addr_ff + 6'h01);
                    sp_done_ff <= ~sp_ai_ff;
                end
            end
            else if (sclk_fall && sp_cmd_ff && !sp_wr_ff)
            begin
                dout <= sp_shout_ff[23] & ~sp_done_ff;
                sp_shout_ff <= {sp_shout_ff[22:0], 1'b0};
            end
        end
    end

    // Registers and the measurement sequencer share one process so that hardware
    // sets land after software writes and win in the same cycle.
    always @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            first_setup_reg_ff <= `TOFS_RST_SETUP1;
            second_setup_reg_ff <= `TOFS_RST_SETUP2;
            status_ff <= `TOFS_RST_STATUS;
            mask_ff <= `TOFS_RST_MASK;
            coarse_ovf_high_ff <= `TOFS_RST_OVF;
            coarse_ovf_low_ff <= `TOFS_RST_OVF;
            clock_ovf_high_ff <= `TOFS_RST_OVF;
            clock_ovf_low_ff <= `TOFS_RST_OVF;
            stop_window_high_ff <= `TOFS_RST_SWIN;
            stop_window_low_ff <= `TOFS_RST_SWIN;
            for (i = 0; i < 6; i = i + 1)
                fine_time_result_ff[i] <= `TOFS_RST_RES;
            for (i = 0; i < 5; i = i + 1)
                clock_cycle_result_ff[i] <= `TOFS_RST_RES;
            cal_single_period_result_ff <= `TOFS_RST_RES;
            cal_multi_period_result_ff <= `TOFS_RST_RES;
            state_ff <= ST_IDLE;
            cnt_ff <= `TOFS_RST_RES;
            cal_cnt_ff <= `TOFS_RST_RES;
            stop_idx_ff <= 3'h0;
            avg_cnt_ff <= 8'h00;
            start_prev_ff <= 1'b0;
            stop_prev_ff <= 1'b0;
            trigger_out <= 1'b0;
            interrupt_out_n <= 1'b1;
        end
        else
        begin
            start_prev_ff <= start_s;
            stop_prev_ff <= stop_s;
            interrupt_out_n <= ~|(status_ff & mask_ff);
            // Host writes; a one written to a status bit clears it.
            if (wr_stb_ff)
            begin
                if (wr_addr_ff == `TOFS_ADDR_SETUP1)
                    first_setup_reg_ff <= wr_data_ff;
                else if (wr_addr_ff == `TOFS_ADDR_SETUP2)
                    second_setup_reg_ff <= wr_data_ff;
                else if (wr_addr_ff == `TOFS_ADDR_STATUS)
                    status_ff <= status_ff & ~wr_data_ff;
                else if (wr_addr_ff == `TOFS_ADDR_MASK)
                    mask_ff <= wr_data_ff;
                else if (wr_addr_ff == `TOFS_ADDR_COV_H)
                    coarse_ovf_high_ff <= wr_data_ff;
                else if (wr_addr_ff == `TOFS_ADDR_COV_L)
                    coarse_ovf_low_ff <= wr_data_ff;
                else if (wr_addr_ff == `TOFS_ADDR_KOV_H)
                    clock_ovf_high_ff <= wr_data_ff;
                else if (wr_addr_ff == `TOFS_ADDR_KOV_L)
                    clock_ovf_low_ff <= wr_data_ff;
                else if (wr_addr_ff == `TOFS_ADDR_SWIN_H)
                    stop_window_high_ff <= wr_data_ff;
                else if (wr_addr_ff == `TOFS_ADDR_SWIN_L)
                    stop_window_low_ff <= wr_data_ff;
            end
            case (state_ff)
                ST_IDLE:
                begin
                    if (first_setup_reg_ff[`TOFS_S1_START])
                    begin
                        for (i = 0; i < 6; i = i + 1)
                            fine_time_result_ff[i] <= `TOFS_RST_RES;
                        for (i = 0; i < 5; i = i + 1)
                            clock_cycle_result_ff[i] <= `TOFS_RST_RES;
                        avg_cnt_ff <= 8'h00;
                        trigger_out <= 1'b1;
                        state_ff <= ST_ARMED;
                    end
                end
                ST_ARMED:
                begin
                    // Waits with no limit; only a start edge moves on.
                    if (start_hit)
                    begin
                        trigger_out <= 1'b0;
                        cnt_ff <= `TOFS_RST_RES;
                        stop_idx_ff <= 3'h0;
                        state_ff <= ST_RUN;
                    end
                end
                ST_RUN:
                begin
                    cnt_ff <= cnt_ff + `TOFS_CAL_ONE;
                    if (kov_hit || cov_hit)
                    begin
                        // An overflow ends the whole series, averaging included.
                        status_ff[`TOFS_ST_KOV] <= kov_hit;
                        status_ff[`TOFS_ST_COV] <= cov_hit;
                        first_setup_reg_ff[`TOFS_S1_START] <= 1'b0;
                        state_ff <= ST_IDLE;
                    end
                    else if (stop_hit && stop_open)
                    begin
                        // Averaging sums every cycle into the same slots.
                        if (long_mode)
                        begin
                            clock_cycle_result_ff[stop_idx_ff] <=
                                clock_cycle_result_ff[stop_idx_ff] + cnt_ff;
                            fine_time_result_ff[stop_idx_ff + 3'h1] <=
                                fine_time_result_ff[stop_idx_ff + 3'h1];
                        end
                        else
                            fine_time_result_ff[stop_idx_ff] <=
                                fine_time_result_ff[stop_idx_ff] + cnt_ff;
                        stop_idx_ff <= stop_idx_ff + 3'h1;
                        if (stop_idx_ff == last_stop)
                        begin
                            cal_cnt_ff <= `TOFS_RST_RES;
                            state_ff <= ST_CAL;
                        end
                    end
                end
                ST_CAL:
                begin
                    cal_cnt_ff <= cal_cnt_ff + `TOFS_CAL_ONE;
                    if (cal_cnt_ff == cal_len - `TOFS_CAL_ONE)
                    begin
                        cal_single_period_result_ff <= `TOFS_CAL_ONE;
                        cal_multi_period_result_ff <= cal_len;
                        if (avg_last)
                        begin
                            status_ff[`TOFS_ST_DONE] <= 1'b1;
                            first_setup_reg_ff[`TOFS_S1_START] <= 1'b0;
                            state_ff <= ST_IDLE;
                        end
                        else
                        begin
                            avg_cnt_ff <= avg_cnt_ff + 8'h01;
                            trigger_out <= 1'b1;
                            state_ff <= ST_ARMED;
                        end
                    end
                end
                default:
                    state_ff <= ST_IDLE;
            endcase
        end
    end
endmodule

// ==== core/tofs_consts.vh ====
`ifndef TOFS_CONSTS_VH
`define TOFS_CONSTS_VH

// Register addresses carried in the low six bits of the command byte.
`define TOFS_ADDR_SETUP1 6'h00
`define TOFS_ADDR_SETUP2 6'h01
`define TOFS_ADDR_STATUS 6'h02
`define TOFS_ADDR_MASK 6'h03
`define TOFS_ADDR_COV_H 6'h04
`define TOFS_ADDR_COV_L 6'h05
`define TOFS_ADDR_KOV_H 6'h06
`define TOFS_ADDR_KOV_L 6'h07
`define TOFS_ADDR_SWIN_H 6'h08
`define TOFS_ADDR_SWIN_L 6'h09
`define TOFS_ADDR_RES_FIRST 6'h10
`define TOFS_ADDR_RES_LAST 6'h1a
`define TOFS_ADDR_CAL1 6'h1b
`define TOFS_ADDR_CAL2 6'h1c

// Command byte fields.
`define TOFS_CMD_AI 7
`define TOFS_CMD_WR 6
`define TOFS_CMD_ADDR_HI 5

// First setup register fields.
`define TOFS_S1_START 0
`define TOFS_S1_MODE 1
`define TOFS_S1_START_EDGE 3
`define TOFS_S1_STOP_EDGE 4

// Second setup register fields.
`define TOFS_S2_CAL_HI 7
`define TOFS_S2_CAL_LO 6
`define TOFS_S2_AVG_HI 5
`define TOFS_S2_AVG_LO 3
`define TOFS_S2_NSTOP_HI 2
`define TOFS_S2_NSTOP_LO 0

// Status register fields.
`define TOFS_ST_DONE 0
`define TOFS_ST_COV 1
`define TOFS_ST_KOV 2

// Reset values.
`define TOFS_RST_SETUP1 8'h00
`define TOFS_RST_SETUP2 8'h40
`define TOFS_RST_STATUS 8'h00
`define TOFS_RST_MASK 8'h07
`define TOFS_RST_OVF 8'hff
`define TOFS_RST_SWIN 8'h00
`define TOFS_RST_RES 24'h00_0000

// Stop slots and calibration lengths in reference clock periods.
`define TOFS_LAST_STOP 3'h4
`define TOFS_CAL_P0 24'h00_0002
`define TOFS_CAL_P1 24'h00_000a
`define TOFS_CAL_P2 24'h00_0014
`define TOFS_CAL_P3 24'h00_0028
`define TOFS_CAL_ONE 24'h00_0001

// Serial bit counts, minus one.
`define TOFS_BYTE_END 5'h07
`define TOFS_WORD_END 5'h17

`endif

// ==== core/tofs_sync2.v ====
`timescale 1ns/1ps

// Two flip-flop synchroniser for asynchronous pins; only q leaves the module.
module tofs_sync2 #(
    parameter WIDTH = 1
) (
    clk_sys,
    rst_n,
    d,
    q
);
    input wire clk_sys;
    input wire rst_n;
    input wire [WIDTH-1:0] d;
    output reg [WIDTH-1:0] q;

    reg [WIDTH-1:0] meta_ff;

    // The first stage feeds the second stage and nothing else.
    always @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            meta_ff <= {WIDTH{1'b0}};
            q <= {WIDTH{1'b0}};
        end
        else
        begin
            meta_ff <= d;
            q <= meta_ff;
        end
    end
endmodule

// ==== verif/tofs_seq_chk.sv ====
`timescale 1ns/1ps

// Watches the pins of the sequencer; all checks live in the one clock domain.
module tofs_seq_chk (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic sclk,
    input wire logic chip_select_n,
    input wire logic din,
    input wire logic dout,
    input wire logic dout_oe_n,
    input wire logic start_in,
    input wire logic stop_in,
    input wire logic trigger_out,
    input wire logic interrupt_out_n
);
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_n);

    // Trigger and start pin relations, with slack for the two-stage synchroniser.
    a_trig_drop_start: assert property (trigger_out && $rose(start_in)
        |-> ##[2:5] !trigger_out)
        else $error("trigger stayed high after a start edge");
    a_trig_wait_start: assert property (trigger_out && !start_in && !$past(start_in)
        && !$past(start_in, 2) && !$past(start_in, 3) |=> trigger_out)
        else $error("trigger dropped without a start edge");
    a_trig_fall_cause: assert property ($fell(trigger_out) |-> $past(start_in, 2)
        || $past(start_in, 3) || $past(start_in, 4) || $past(start_in, 5))
        else $error("trigger fell with no start pulse before it");
    a_trig_retrig_gap: assert property ($fell(trigger_out) |=> !trigger_out [*3])
        else $error("trigger rose again before calibration could finish");
    // Interrupt is only shown once the sequence has stopped driving the trigger.
    a_int_no_trig: assert property (!interrupt_out_n |-> !trigger_out)
        else $error("interrupt asserted while trigger active");
    a_int_held_low: assert property (!interrupt_out_n && chip_select_n
        && $past(chip_select_n) |=> !interrupt_out_n)
        else $error("interrupt released without a serial access");
    // The serial output is driven only inside a selected frame.
    a_oe_cs_abort: assert property ($rose(chip_select_n) |-> ##[1:5] dout_oe_n)
        else $error("data output still driven after deselect");
    a_oe_idle_off: assert property (chip_select_n && $past(chip_select_n, 5)
        |-> dout_oe_n)
        else $error("data output driven while not selected");
    a_dout_shift_low: assert property (!dout_oe_n && !$past(dout_oe_n)
        && $changed(dout) |-> !sclk && !$past(sclk))
        else $error("read data changed while serial clock high");

    c_trig_done: cover property ($fell(trigger_out));
    c_int_seen: cover property ($fell(interrupt_out_n));
    c_read_seen: cover property ($fell(dout_oe_n));
endmodule

bind tofs_sequencer tofs_seq_chk i_tofs_seq_chk (.clk_sys(clk_sys), .rst_n(rst_n), .sclk(sclk),
    .chip_select_n(chip_select_n), .din(din), .dout(dout), .dout_oe_n(dout_oe_n),
    .start_in(start_in), .stop_in(stop_in), .trigger_out(trigger_out),
    .interrupt_out_n(interrupt_out_n));

// ==== verif/tofs_afe_model.sv ====
`timescale 1ns/1ps

// Front end: answers each trigger with a start pulse and up to three stop pulses.
module tofs_afe_model (
    input wire logic clk_sys,
    input wire logic trigger_out,
    input wire logic [1:0] n_stop,
    input wire logic [15:0] off0,
    input wire logic [15:0] off1,
    input wire logic [15:0] off2,
    output logic start_in,
    output logic stop_in,
    output logic [7:0] trig_count
);
    int t;
    int lim;

    // Pulses last four cycles so the synchronised edge is never missed.
    initial
    begin
        start_in = 1'b0;
        stop_in = 1'b0;
        trig_count = 8'h00;
        forever
        begin
            @(negedge clk_sys);
            if (trigger_out === 1'b1)
            begin
                trig_count = trig_count + 8'h01;
                repeat (5) @(negedge clk_sys);
                lim = (n_stop == 2'h0) ? 6 : (n_stop == 2'h1) ? off0 + 6 :
                    (n_stop == 2'h2) ? off1 + 6 : off2 + 6;
                start_in = 1'b1;
                for (t = 1; t <= lim; t++)
                begin
                    @(negedge clk_sys);
                    start_in = (t < 4);
                    stop_in = (n_stop >= 2'h1 && t >= off0 && t < off0 + 4)
                        || (n_stop >= 2'h2 && t >= off1 && t < off1 + 4)
                        || (n_stop == 2'h3 && t >= off2 && t < off2 + 4);
                end
            end
        end
    end
endmodule

// ==== verif/tofs_sequencer_tb.sv ====
`timescale 1ns/1ps
`include "tofs_consts.vh"

module tofs_sequencer_tb;
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    logic sclk = 1'b0;
    logic chip_select_n = 1'b1;
    logic din = 1'b0;
    logic [1:0] n_stop = 2'h0;
    logic [15:0] off0 = 16'h0000;
    logic [15:0] off1 = 16'h0000;
    logic [15:0] off2 = 16'h0000;
    wire dout;
    wire dout_oe_n;
    wire start_in;
    wire stop_in;
    wire trigger_out;
    wire interrupt_out_n;
    wire [7:0] trig_count;
    int fail_count = 0;
    int n_tests = 0;
    logic [23:0] v;
    logic [7:0] t0;

    // Reference clock at 100 MHz.
    always #5 clk_sys = ~clk_sys;

    tofs_sequencer i_tofs_sequencer (.clk_sys(clk_sys), .rst_n(rst_n), .sclk(sclk),
        .chip_select_n(chip_select_n), .din(din), .dout(dout), .dout_oe_n(dout_oe_n),
        .start_in(start_in), .stop_in(stop_in), .trigger_out(trigger_out),
        .interrupt_out_n(interrupt_out_n));
    tofs_afe_model i_tofs_afe_model (.clk_sys(clk_sys), .trigger_out(trigger_out),
        .n_stop(n_stop), .off0(off0), .off1(off1), .off2(off2), .start_in(start_in),
        .stop_in(stop_in), .trig_count(trig_count));

    task automatic conclude;
        $display("fail_count=%0d n_tests=%0d", fail_count, n_tests);
        if (fail_count == 0 && n_tests > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    // Range compare; an unknown value never lands inside the range.
    task automatic chk(input string name, input logic [23:0] lo, input logic [23:0] hi,
        input logic [23:0] got);
        n_tests++;
        if ((got >= lo && got <= hi) !== 1'b1)
        begin
            fail_count++;
            $display("unexpected %s: expected %0h..%0h, seen %0h", name, lo, hi, got);
        end
    endtask

    // One frame: sclk half period is four cycles and the clock rests low between frames.
    task automatic frame(input logic [7:0] cmd, input logic [23:0] wd, input int nb,
        input int cut, output logic [23:0] rd);
        logic [31:0] sh;
        int i;
        sh = {cmd, 24'h00_0000};
        sh[23:0] = wd << (24 - nb);
        rd = 24'h00_0000;
        @(negedge clk_sys);
        chip_select_n = 1'b0;
        repeat (4) @(negedge clk_sys);
        for (i = 0; i < 8 + nb && i < cut; i++)
        begin
            din = sh[31 - i];
            repeat (4) @(negedge clk_sys);
            sclk = 1'b1;
            repeat (4) @(negedge clk_sys);
            if (i >= 8)
                rd = {rd[22:0], dout};
            sclk = 1'b0;
        end
        repeat (4) @(negedge clk_sys);
        chip_select_n = 1'b1;
        din = ~din;
        repeat (8) @(negedge clk_sys);
    endtask

    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        frame({2'b01, a}, {16'h0000, d}, 8, 99, v);
    endtask

    task automatic rd(input logic [5:0] a, input int nb);
        frame({2'b00, a}, 24'h00_0000, nb, 99, v);
    endtask

    // Completion is taken from the interrupt pin only, never by polling status.
    task automatic wait_int(input int lim);
        int i;
        for (i = 0; i < lim && interrupt_out_n !== 1'b0; i++)
            @(negedge clk_sys);
        chk("interrupt_out_n", 24'h0, 24'h0, {23'h0, interrupt_out_n});
        if (interrupt_out_n !== 1'b0)
            conclude();
    endtask

    task automatic s_reset_vals;
        rd(`TOFS_ADDR_SETUP2, 8);
        chk("setup2", 24'h40, 24'h40, v);
        rd(`TOFS_ADDR_MASK, 8);
        chk("mask", 24'h07, 24'h07, v);
        rd(`TOFS_ADDR_RES_FIRST + 6'h01, 24);
        chk("clock result 1", 24'h0, 24'h0, v);
        frame(8'h81, 24'h00_0000, 16, 99, v);
        chk("auto increment read", 24'h4000, 24'h4000, v);
    endtask

    // Stop at 10 falls inside the 20-cycle mask; only two of the later stops count.
    task automatic s_two_stops;
        wr(`TOFS_ADDR_SWIN_L, 8'h14);
        wr(`TOFS_ADDR_SETUP2, 8'h41);
        n_stop = 2'h3;
        off0 = 16'd10;
        off1 = 16'd30;
        off2 = 16'd45;
        t0 = trig_count;
        wr(`TOFS_ADDR_SETUP1, 8'h03);
        wait_int(3000);
        chk("trigger count", 24'h1, 24'h1, {16'h0, trig_count - t0});
        rd(`TOFS_ADDR_RES_FIRST + 6'h01, 24);
        chk("clock result 1", 24'd29, 24'd30, v);
        rd(`TOFS_ADDR_RES_FIRST + 6'h03, 24);
        chk("clock result 2", 24'd44, 24'd45, v);
        rd(`TOFS_ADDR_RES_FIRST + 6'h05, 24);
        chk("clock result 3", 24'h0, 24'h0, v);
        rd(`TOFS_ADDR_RES_FIRST, 24);
        chk("start fraction", 24'h0, 24'h0, v);
        rd(`TOFS_ADDR_STATUS, 8);
        chk("status", 24'h01, 24'h01, v);
        wr(`TOFS_ADDR_STATUS, 8'h01);
        chk("interrupt_out_n", 24'h1, 24'h1, {23'h0, interrupt_out_n});
    endtask

    // Largest series: 128 cycles, accumulated count shifted back by seven.
    task automatic s_average;
        wr(`TOFS_ADDR_SETUP2, 8'h78);
        n_stop = 2'h1;
        off0 = 16'd30;
        t0 = trig_count;
        wr(`TOFS_ADDR_SETUP1, 8'h03);
        wait_int(30000);
        chk("trigger count", 24'd128, 24'd128, {16'h0, trig_count - t0});
        rd(`TOFS_ADDR_RES_FIRST + 6'h01, 24);
        chk("averaged clock result", 24'd29, 24'd30, v >> 7);
        wr(`TOFS_ADDR_STATUS, 8'h01);
    endtask

    task automatic s_abort;
        frame({2'b01, `TOFS_ADDR_SWIN_L}, 24'h00_00ff, 8, 12, v);
        rd(`TOFS_ADDR_SWIN_L, 8);
        chk("window after abort", 24'h14, 24'h14, v);
    endtask

    // No stop arrives, so a clock limit of 10 must end the measurement.
    task automatic s_overflow;
        wr(`TOFS_ADDR_KOV_H, 8'h00);
        wr(`TOFS_ADDR_KOV_L, 8'h0a);
        wr(`TOFS_ADDR_SWIN_L, 8'h00);
        wr(`TOFS_ADDR_SETUP2, 8'h40);
        n_stop = 2'h0;
        wr(`TOFS_ADDR_SETUP1, 8'h03);
        wait_int(500);
        rd(`TOFS_ADDR_STATUS, 8);
        chk("status", 24'h04, 24'h04, v);
        chk("trigger_out", 24'h0, 24'h0, {23'h0, trigger_out});
        wr(`TOFS_ADDR_STATUS, 8'h04);
    endtask

    task automatic s_enable;
        rst_n = 1'b0;
        repeat (5) @(negedge clk_sys);
        rst_n = 1'b1;
        repeat (5) @(negedge clk_sys);
        rd(`TOFS_ADDR_SWIN_L, 8);
        chk("window", 24'h00, 24'h00, v);
        rd(`TOFS_ADDR_KOV_L, 8);
        chk("clock limit low", 24'hff, 24'hff, v);
    endtask

    // Main sequence; serial access only starts after the enable has settled.
    initial
    begin
        repeat (5) @(negedge clk_sys);
        rst_n = 1'b1;
        repeat (5) @(negedge clk_sys);
        s_reset_vals();
        s_two_stops();
        s_average();
        s_abort();
        s_overflow();
        s_enable();
        conclude();
    end
endmodule
